// ---- hw/bus_cycle_trace_capture.v ----
// Bus cycle trace capture with register port and event monitor feed.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "trace_capture_consts.vh"
module bus_cycle_trace_capture #(
  parameter AW = 10
) (
  input  wire                   mclk_in,
  input  wire                   nrst_in,
  input  wire                   cyc_valid_in,
  input  wire [`TC_ADDR_W-1:0]  cyc_addr_in,
  input  wire [`TC_DATA_W-1:0]  cyc_data_in,
  input  wire                   cyc_write_in,
  input  wire                   cyc_overlay_in,
  input  wire                   cyc_io_in,
  input  wire [3:0]             cycle_type_field_in,
  input  wire [1:0]             segment_class_field_in,
  input  wire [2:0]             prefetch_queue_field_in,
  input  wire                   cyc_flush_in,
  input  wire [`TC_POD_W-1:0]   analyzer_pod_pins_in,
  input  wire                   pause_in,
  input  wire [3:0]             reg_addr_in,
  input  wire [31:0]            reg_wdata_in,
  input  wire                   reg_wr_in,
  input  wire                   reg_rd_in,
  output reg  [31:0]            reg_rdata_out,
  output reg                    mon_valid_out,
  output reg  [`TC_REC_W-1:0]   mon_record_out,
  output reg                    paused_out,
  output reg                    irq_out
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  reg rst_s1_r;
  reg rst_n_r;

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // Pod pin and pause synchronisers
  // ---------------------------------------------------------------
  reg [`TC_POD_W-1:0] pod_s1_r;
  reg [`TC_POD_W-1:0] pod_s2_r;
  reg [`TC_POD_W-1:0] pod_s3_r;
  reg [`TC_POD_W-1:0] pod_r;
  reg [2:0]           pause_sync_r;
  reg                 pause_r;

  // A bit changes once the second and third stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < `TC_POD_W; gi = gi + 1) begin : g_pod
      always @(posedge mclk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
          pod_r[gi] <= 1'b0;
        end else if (pod_s2_r[gi] == pod_s3_r[gi]) begin
          pod_r[gi] <= pod_s3_r[gi];
        end
      end
    end
  endgenerate

  always @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pod_s1_r     <= {`TC_POD_W{1'b0}};
      pod_s2_r     <= {`TC_POD_W{1'b0}};
      pod_s3_r     <= {`TC_POD_W{1'b0}};
      pause_sync_r <= 3'h0;
      pause_r      <= 1'b0;
    end else begin
      pod_s1_r     <= analyzer_pod_pins_in;
      pod_s2_r     <= pod_s1_r;
      pod_s3_r     <= pod_s2_r;
      pause_sync_r <= {pause_sync_r[1:0], pause_in};
      if (pause_sync_r[1] == pause_sync_r[2]) begin
        pause_r <= pause_sync_r[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register and run state
  // ---------------------------------------------------------------
  reg  [1:0] ctrl_r;
  wire       capture_en = ctrl_r[0];
  wire       soft_pause = ctrl_r[1];
  wire       frozen     = pause_r | soft_pause;

  // ---------------------------------------------------------------
  // Record assembly
  // ---------------------------------------------------------------
  wire [`TC_REC_W-1:0] record;
  assign record = {analyzer_pod_pins_snapshot(pod_r),
                   cyc_flush_in,
                   queue_value(prefetch_queue_field_in),
                   segment_class_field_in,
                   cycle_type_field_in,
                   cyc_io_in,
                   cyc_overlay_in,
                   cyc_write_in,
                   cyc_data_in,
                   cyc_addr_in};

  function [`TC_POD_W-1:0] analyzer_pod_pins_snapshot;
    input [`TC_POD_W-1:0] pins;
    analyzer_pod_pins_snapshot = {pins[15:8], pins[7:0]};
  endfunction

  // A depth beyond six is clipped, a flush count is kept as given.
  function [2:0] queue_value;
    input [2:0] q;
    if (!cyc_flush_in && q > `TC_QUE_MAX) begin
      queue_value = `TC_QUE_MAX;
    end else begin
      queue_value = q;
    end
  endfunction

  // ---------------------------------------------------------------
  // Circular write pointer and fill count
  // ---------------------------------------------------------------
  reg  [AW-1:0] wptr_r;
  reg  [AW:0]   count_r;
  reg  [AW-1:0] index_r;
  wire          capture = cyc_valid_in & capture_en & ~frozen;
  wire [AW:0]   depth   = {1'b1, {AW{1'b0}}};

  always @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wptr_r  <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else if (capture) begin
      wptr_r <= wptr_r + {{(AW-1){1'b0}}, 1'b1};
      if (count_r != depth) begin
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // Index zero is the newest entry; larger indices step back in time.
  wire [AW-1:0] raddr = wptr_r - index_r - {{(AW-1){1'b0}}, 1'b1};
  wire [`TC_REC_W-1:0] rdata;

  trace_mem #(
    .AW (AW),
    .DW (`TC_REC_W)
  ) u_mem (
    .clk_in    (mclk_in),
    .we_in     (capture),
    .waddr_in  (wptr_r),
    .wdata_in  (record),
    .raddr_in  (raddr),
    .rdata_out (rdata)
  );

  // ---------------------------------------------------------------
  // Event monitor feed
  // ---------------------------------------------------------------
  always @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mon_valid_out  <= 1'b0;
      mon_record_out <= {`TC_REC_W{1'b0}};
      paused_out     <= 1'b0;
    end else begin
      mon_valid_out <= cyc_valid_in & ~frozen;
      paused_out    <= frozen;
      if (cyc_valid_in) begin
        mon_record_out <= record;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  reg        frozen_d_r;
  reg  [2:0] irq_stat_r;
  reg  [2:0] irq_en_r;
  reg        rd_refused;
  wire       wrap_ev  = capture & (count_r == depth);
  wire       pause_ev = frozen & ~frozen_d_r;
  wire [2:0] irq_set  = {rd_refused, wrap_ev, pause_ev};
  wire [2:0] irq_clr  = (reg_wr_in && reg_addr_in == `TC_REG_IRQ_CLR) ?
                        reg_wdata_in[2:0] : 3'h0;

  always @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      frozen_d_r <= 1'b0;
      irq_stat_r <= 3'h0;
      irq_out    <= 1'b0;
    end else begin
      frozen_d_r <= frozen;
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq_out    <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  reg [3:0] rd_addr_r;
  reg       rd_pend_r;

  always @* begin
    rd_refused = 1'b0;
    if (reg_rd_in && !frozen && reg_addr_in >= `TC_REG_REC0 &&
        reg_addr_in <= `TC_REG_REC3) begin
      rd_refused = 1'b1;
    end
  end

  always @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r    <= `TC_CTRL_RST;
      irq_en_r  <= `TC_IRQ_EN_RST;
      index_r   <= {AW{1'b0}};
      rd_addr_r <= 4'h0;
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= reg_rd_in;
      if (reg_rd_in) begin
        rd_addr_r <= reg_addr_in;
      end
      if (reg_wr_in) begin
        case (reg_addr_in)
          `TC_REG_CTRL:   ctrl_r   <= reg_wdata_in[1:0];
          `TC_REG_INDEX:  index_r  <= reg_wdata_in[AW-1:0];
          `TC_REG_IRQ_EN: irq_en_r <= reg_wdata_in[2:0];
          default:        ctrl_r   <= ctrl_r;
        endcase
      end
    end
  end

  // Record words come from the memory's registered output one cycle on.
  always @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `TC_REG_CTRL:     reg_rdata_out <= {30'h0, ctrl_r};
        `TC_REG_STATUS:   reg_rdata_out <= {30'h0, capture_en, frozen};
        `TC_REG_INDEX:    reg_rdata_out <= {{(32-AW){1'b0}}, index_r};
        `TC_REG_COUNT:    reg_rdata_out <= {{(31-AW){1'b0}}, count_r};
        `TC_REG_IRQ_STAT: reg_rdata_out <= {29'h0, irq_stat_r};
        `TC_REG_IRQ_EN:   reg_rdata_out <= {29'h0, irq_en_r};
        `TC_REG_REC0:     reg_rdata_out <= frozen ? rdata[31:0] : 32'h0;
        `TC_REG_REC1:     reg_rdata_out <= frozen ? rdata[63:32] : 32'h0;
        `TC_REG_REC2:     reg_rdata_out <= frozen ?
                                           {31'h0, rdata[64]} : 32'h0;
        default:          reg_rdata_out <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ---- hw/trace_capture_consts.vh ----
// Constants for the bus cycle trace capture block.
`ifndef TRACE_CAPTURE_CONSTS_VH
`define TRACE_CAPTURE_CONSTS_VH

// ---------------------------------------------------------------
// Record field widths and positions
// ---------------------------------------------------------------
`define TC_ADDR_W        20
`define TC_DATA_W        16
`define TC_POD_W         16
`define TC_REC_W         65
`define TC_ADDR_LSB      0
`define TC_DATA_LSB      20
`define TC_DIR_BIT       36
`define TC_OVL_BIT       37
`define TC_MIO_BIT       38
`define TC_CYC_LSB       39
`define TC_SEG_LSB       43
`define TC_QUE_LSB       45
`define TC_FLUSH_BIT     48
`define TC_POD_LSB       49

// ---------------------------------------------------------------
// Cycle type codes
// ---------------------------------------------------------------
`define TC_CYC_REFRESH   4'h0
`define TC_CYC_INTA      4'h1
`define TC_CYC_IO_RD     4'h2
`define TC_CYC_IO_WR     4'h3
`define TC_CYC_HALT      4'h4
`define TC_CYC_FETCH     4'h5
`define TC_CYC_MEM_RD    4'h6
`define TC_CYC_MEM_WR    4'h7
`define TC_CYC_DMA       4'h8

// ---------------------------------------------------------------
// Segment class codes and queue limit
// ---------------------------------------------------------------
`define TC_SEG_ALT       2'h0
`define TC_SEG_CODE      2'h1
`define TC_SEG_DATA      2'h2
`define TC_SEG_STACK     2'h3
`define TC_QUE_MAX       3'h6

// ---------------------------------------------------------------
// Register offsets and reset values
// ---------------------------------------------------------------
`define TC_REG_CTRL      4'h0
`define TC_REG_STATUS    4'h1
`define TC_REG_INDEX     4'h2
`define TC_REG_COUNT     4'h3
`define TC_REG_REC0      4'h4
`define TC_REG_REC1      4'h5
`define TC_REG_REC2      4'h6
`define TC_REG_REC3      4'h7
`define TC_REG_IRQ_STAT  4'h8
`define TC_REG_IRQ_EN    4'h9
`define TC_REG_IRQ_CLR   4'hA
`define TC_CTRL_RST      2'h0
`define TC_IRQ_EN_RST    3'h0
`define TC_IRQ_W         3

`endif

// ---- hw/trace_mem.v ----
// Trace record memory with registered read data.
`timescale 1ns/100ps
`default_nettype none
module trace_mem #(
  parameter AW = 10,
  parameter DW = 65
) (
  input  wire          clk_in,
  input  wire          we_in,
  input  wire [AW-1:0] waddr_in,
  input  wire [DW-1:0] wdata_in,
  input  wire [AW-1:0] raddr_in,
  output reg  [DW-1:0] rdata_out
);

  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  always @(posedge clk_in) begin
    if (we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
    rdata_out <= mem_r[raddr_in];
  end

endmodule
`default_nettype wire

// ---- verification/proc_bus_model.sv ----
// Behavioural processor bus and analyzer pod issuing traced cycles.
`timescale 1ns/100ps
`default_nettype none
module proc_bus_model (
  input  wire logic        clk_in,
  output var  logic        valid_out,
  output var  logic [19:0] addr_out,
  output var  logic [15:0] data_out,
  output var  logic        write_out,
  output var  logic        ovl_out,
  output var  logic        io_out,
  output var  logic [3:0]  type_out,
  output var  logic [1:0]  seg_out,
  output var  logic [2:0]  queue_out,
  output var  logic        flush_out,
  output var  logic [15:0] pod_out
);
  initial begin
    {valid_out, addr_out, data_out, write_out, ovl_out, io_out} = 0;
    {type_out, seg_out, queue_out, flush_out, pod_out} = 0;
  end
  // Fields of cycle n, packed in trace record order, queue unclipped.
  function automatic [64:0] raw(input [7:0] n);
    reg [7:0] t9;
    reg [7:0] t5;
    begin
      t9 = n % 8'h09;
      t5 = n % 8'h05;
      raw = {n, ~n, t5 == 8'h00, n[2:0], n[3:2], t9[3:0], n[2], n[1], n[0],
             ~n, n, 12'h100, n};
    end
  endfunction
  // Pod pins settle well ahead of the cycle, as the pod synchroniser needs.
  task automatic issue(input [7:0] n);
    reg [64:0] r;
    begin
      r = raw(n);
      @(posedge clk_in);
      pod_out <= r[64:49];
      repeat (8) @(posedge clk_in);
      valid_out <= 1'b1;
      {flush_out, queue_out, seg_out, type_out, io_out, ovl_out, write_out,
       data_out, addr_out} <= r[48:0];
      @(posedge clk_in);
      valid_out <= 1'b0;
      addr_out <= ~r[19:0];
      data_out <= ~r[35:20];
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking testbench for the bus cycle trace capture block.
`timescale 1ns/100ps
`default_nettype none
`include "trace_capture_consts.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb;
  logic        mclk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        pause_in = 1'b0;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  wire  [31:0] reg_rdata_out;
  wire         mon_valid_out;
  wire  [64:0] mon_record_out;
  wire         paused_out;
  wire         irq_out;
  wire         v, w, o, io, fl;
  wire  [19:0] a;
  wire  [15:0] d, pod;
  wire  [3:0]  ty;
  wire  [1:0]  sg;
  wire  [2:0]  q;
  int          miscompares = 0;
  int          checks = 0;
  logic [7:0]  n;
  logic [31:0] r0, r1, r2;
  always #25 mclk_in = ~mclk_in;
  proc_bus_model bus (.clk_in(mclk_in), .valid_out(v), .addr_out(a),
    .data_out(d), .write_out(w), .ovl_out(o), .io_out(io), .type_out(ty),
    .seg_out(sg), .queue_out(q), .flush_out(fl), .pod_out(pod));
  bus_cycle_trace_capture #(.AW(4)) dut (.mclk_in(mclk_in),
    .nrst_in(nrst_in), .cyc_valid_in(v), .cyc_addr_in(a), .cyc_data_in(d),
    .cyc_write_in(w), .cyc_overlay_in(o), .cyc_io_in(io),
    .cycle_type_field_in(ty), .segment_class_field_in(sg),
    .prefetch_queue_field_in(q), .cyc_flush_in(fl),
    .analyzer_pod_pins_in(pod), .pause_in(pause_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .mon_valid_out(mon_valid_out),
    .mon_record_out(mon_record_out), .paused_out(paused_out),
    .irq_out(irq_out));
  // ---------------------------------------------------------------
  // Register port tasks and expectations
  // ---------------------------------------------------------------
  task automatic wr(input [3:0] ad, input [31:0] wd);
    @(posedge mclk_in);
    reg_addr_in <= ad;
    reg_wdata_in <= wd;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input [3:0] ad, output [31:0] rdat);
    @(posedge mclk_in);
    reg_addr_in <= ad;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1;
    rdat = reg_rdata_out;
  endtask
  task automatic rchk(input [3:0] ad, input [31:0] e, input string nm);
    logic [31:0] g;
    rd(ad, g);
    `CHK(nm, e, g)
  endtask
  function automatic [64:0] expect_rec(input [7:0] k);
    reg [64:0] r;
    begin
      r = bus.raw(k);
      if (!r[48] && r[47:45] > 3'h6)
        r[47:45] = 3'h6;
      expect_rec = r;
    end
  endfunction
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk_in);
    miscompares++;
    results;
  end
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rchk(`TC_REG_REC0, 32'h0, "readout while running");
    rchk(`TC_REG_IRQ_STAT, 32'h4, "refusal status");
    rchk(4'hF, 32'h0, "unmapped read");
    wr(`TC_REG_IRQ_CLR, 32'h4);
    wr(`TC_REG_CTRL, 32'h1);
    for (n = 8'h01; n <= 8'h14; n++) begin
      bus.issue(n);
      #1;
      `CHK("monitor valid", 1'b1, mon_valid_out)
      `CHK("monitor record", expect_rec(n), mon_record_out)
    end
    rchk(`TC_REG_COUNT, 32'h10, "entry count");
    $display("test capture done");
    @(posedge mclk_in);
    pause_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    rchk(`TC_REG_STATUS, 32'h3, "frozen status");
    `CHK("paused flag", 1'b1, paused_out)
    bus.issue(8'h15);
    #1;
    `CHK("frozen monitor", 1'b0, mon_valid_out)
    for (n = 8'h00; n < 8'h10; n++) begin
      wr(`TC_REG_INDEX, {24'h000000, n});
      rd(`TC_REG_REC0, r0);
      rd(`TC_REG_REC1, r1);
      rd(`TC_REG_REC2, r2);
      `CHK("trace entry", expect_rec(8'h14 - n), {r2[0], r1, r0})
    end
    $display("test readout done");
    rchk(`TC_REG_IRQ_STAT, 32'h3, "pause and wrap status");
    `CHK("masked irq", 1'b0, irq_out)
    wr(`TC_REG_IRQ_EN, 32'h1);
    repeat (2) @(posedge mclk_in);
    #1;
    `CHK("enabled irq", 1'b1, irq_out)
    wr(`TC_REG_IRQ_CLR, 32'h1);
    repeat (2) @(posedge mclk_in);
    #1;
    `CHK("cleared irq", 1'b0, irq_out)
    rchk(`TC_REG_IRQ_STAT, 32'h2, "status after clear");
    $display("test interrupt done");
    wr(`TC_REG_CTRL, 32'h3);
    @(posedge mclk_in);
    pause_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    rchk(`TC_REG_STATUS, 32'h3, "soft pause status");
    `CHK("soft paused flag", 1'b1, paused_out)
    $display("test soft pause done");
    results;
  end
endmodule
`default_nettype wire

// ---- verification/trace_capture_monitor.sv ----
// Concurrent checks on the ports of the trace capture block.
`timescale 1ns/100ps
`default_nettype none
module trace_capture_monitor (
  input wire logic        mclk_in,
  input wire logic        nrst_in,
  input wire logic        cyc_valid_in,
  input wire logic [19:0] cyc_addr_in,
  input wire logic [15:0] cyc_data_in,
  input wire logic        cyc_write_in,
  input wire logic        cyc_overlay_in,
  input wire logic        cyc_io_in,
  input wire logic [3:0]  cycle_type_field_in,
  input wire logic [1:0]  segment_class_field_in,
  input wire logic [2:0]  prefetch_queue_field_in,
  input wire logic        cyc_flush_in,
  input wire logic [15:0] analyzer_pod_pins_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        mon_valid_out,
  input wire logic [64:0] mon_record_out,
  input wire logic        paused_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // ---------------------------------------------------------------
  // Named steps of a capture
  // ---------------------------------------------------------------
  sequence s_pod_steady;
    $stable(analyzer_pod_pins_in) [*8];
  endsequence
  sequence s_flushed;
    mon_valid_out && $past(cyc_flush_in);
  endsequence
  sequence s_not_flushed;
    mon_valid_out && !$past(cyc_flush_in);
  endsequence
  // ---------------------------------------------------------------
  // Record contents against the bus cycle that caused them, frozen monitor quiet, read data timing
  // ---------------------------------------------------------------
  a_mon_follows_cyc: assert property (mon_valid_out |-> $past(cyc_valid_in))
    else $error("monitor pulse without a bus cycle");
  a_addr_data_kept: assert property (mon_valid_out |->
    mon_record_out[35:0] == {$past(cyc_data_in), $past(cyc_addr_in)})
    else $error("address or data differs from the bus cycle");
  a_dir_bit: assert property (mon_valid_out |->
    mon_record_out[36] == $past(cyc_write_in))
    else $error("direction bit differs from the bus cycle");
  a_space_flags: assert property (mon_valid_out |->
    mon_record_out[38:37] == {$past(cyc_io_in), $past(cyc_overlay_in)})
    else $error("overlay or space flag differs from the bus cycle");
  a_type_seg: assert property (mon_valid_out |->
    mon_record_out[44:39] ==
    {$past(segment_class_field_in), $past(cycle_type_field_in)})
    else $error("cycle type or segment class differs");
  a_queue_depth: assert property (s_not_flushed |->
    !mon_record_out[48] && mon_record_out[47:45] ==
    ($past(prefetch_queue_field_in) > 3'h6 ? 3'h6
     : $past(prefetch_queue_field_in)))
    else $error("queue depth not clipped to six");
  a_flush_count: assert property (s_flushed |->
    mon_record_out[48] && mon_record_out[47:45] ==
    $past(prefetch_queue_field_in))
    else $error("flush mark or flushed count wrong");
  a_pod_latch: assert property (s_pod_steady ##0 mon_valid_out |->
    mon_record_out[64:49] == analyzer_pod_pins_in)
    else $error("analyzer pod pins not latched");
  a_frozen_quiet: assert property ($past(paused_out, 2) && paused_out |->
    !mon_valid_out)
    else $error("capture while frozen");
  a_read_pulse: assert property (reg_rdata_out != 32'h0 |-> $past(reg_rd_in))
    else $error("read data outside the read answer cycle");
endmodule
bind bus_cycle_trace_capture trace_capture_monitor u_mon (.mclk_in,
  .nrst_in, .cyc_valid_in, .cyc_addr_in, .cyc_data_in, .cyc_write_in,
  .cyc_overlay_in, .cyc_io_in, .cycle_type_field_in,
  .segment_class_field_in, .prefetch_queue_field_in, .cyc_flush_in,
  .analyzer_pod_pins_in, .reg_rd_in, .reg_rdata_out, .mon_valid_out,
  .mon_record_out, .paused_out);
`default_nettype wire
